// ==== inc/acf_pkg.sv ====
// Constants, register map and carrier types of the alert and clamp status flags block
package acf_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_THR_FLAGS  = 8'h16;
   localparam logic [7:0] IDX_CLAMP      = 8'h1A;
   localparam logic [7:0] IDX_SETUP      = 8'h20;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
   localparam logic [7:0] IDX_IRQ_MASK   = 8'h31;
   localparam logic [7:0] IDX_DET_EN     = 8'h32;

   // Field positions
   localparam int FIRST_CH       = 4;
   localparam int NUM_CH         = 4;
   localparam int FLAG_LOW_OFS   = 1;
   localparam int FLAG_HIGH_OFS  = 0;
   localparam int ALERT_MODE_BIT = 7;
   localparam int IRQ_CLAMP_BIT  = 8;
   localparam int IRQ_W          = 9;
   localparam int CLAMP_W        = 8;

   // Reset values
   localparam logic [7:0]       THR_FLAGS_RST  = 8'h00;
   localparam logic [7:0]       CLAMP_RST      = 8'h00;
   localparam logic [7:0]       SETUP_RST      = 8'h10;
   localparam logic [IRQ_W-1:0] IRQ_STATUS_RST = 9'h000;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST   = 9'h000;
   localparam logic [3:0]       DET_EN_RST     = 4'h0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // One finished conversion with its comparator verdicts
   typedef struct packed {
      logic       valid;
      logic [2:0] channel;
      logic       at_or_below_low;
      logic       at_or_above_high;
      logic       low_hyst_clear;
      logic       high_hyst_clear;
   } acf_conv_t;
endpackage

// ==== src/acf_status_flags.sv ====
// Alert flag and clamp flag status registers behind an AXI4-Lite slave
`timescale 1ns/100ps

// Contract
// - Low alert flags of channels 7,6,5,4 sit at bits 7,5,3,1.
// - High alert flags of channels 7,6,5,4 sit at bits 6,4,2,0.
// - Result at or below lower threshold sets the channel's low flag.
// - Result at or above upper threshold sets the channel's high flag.
// - Flags change only while detection is enabled for that channel; a read of the alert register clears them regardless.
// - Reading the alert register clears its flags.
// - With alert mode one, a result inside hysteresis clears a set flag.
// - Alert register at index 0x16, resets to zero, read-only.
// - Clamp register at index 0x1A, bit x shows clamp of input x.
// - Clamp bit reads one while that input's clamp is active.
// - Clamp bits never latch; they drop when the clamp releases.
// - Alert mode select is bit 7 of setup register at index 0x20.
module acf_status_flags
   import acf_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst,
   // Conversion verdicts from the threshold comparators
   input  wire acf_conv_t         conv,
   // Raw clamp indicators from the analog inputs
   input  wire logic [CLAMP_W-1:0] clamp_raw,
   // AXI4-Lite write address and data
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Interrupt
   output logic                   irq
);

   // Elaboration check on the address width
   if (ADDR_W < 10) begin : g_bad_addr
      $error("ADDR_W must be at least 10");
   end

   logic [7:0]         thr_flags;
   logic [7:0]         next_thr_flags;
   logic [7:0]         alert_set;
   logic [7:0]         setup;
   logic [7:0]         next_setup;
   logic [3:0]         det_en;
   logic [3:0]         next_det_en;
   logic [IRQ_W-1:0]   irq_status;
   logic [IRQ_W-1:0]   next_irq_status;
   logic [IRQ_W-1:0]   irq_mask;
   logic [IRQ_W-1:0]   next_irq_mask;
   logic               next_irq;
   logic [CLAMP_W-1:0] clamp_meta;
   logic [CLAMP_W-1:0] clamp_sync;
   logic [CLAMP_W-1:0] clamp_prev;
   logic [ADDR_W-1:0]  wr_addr;
   logic [ADDR_W-1:0]  next_wr_addr;
   logic [31:0]        wr_data;
   logic [31:0]        next_wr_data;
   logic [3:0]         wr_strb;
   logic [3:0]         next_wr_strb;
   logic               next_awready;
   logic               next_wready;
   logic               next_bvalid;
   logic [1:0]         next_bresp;
   logic               next_arready;
   logic               next_rvalid;
   logic [31:0]        next_rdata;
   logic [1:0]         next_rresp;
   logic               do_write;
   logic               rd_take;
   logic               rd_clear;
   logic [31:0]        wr_bits;
   logic [ADDR_W-1:0]  wr_word;
   logic [ADDR_W-1:0]  rd_word;

   // Word index of each address
   assign wr_word = wr_addr >> 2;
   assign rd_word = s_axi_araddr >> 2;

   // Write lanes expanded to a bit mask
   assign wr_bits = wr_data & {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

   // Write path: address and data are taken in either order, then one response
   always_comb begin
      next_awready = s_axi_awready;
      next_wready  = s_axi_wready;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      next_wr_strb = wr_strb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      do_write     = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awready && s_axi_awvalid) begin
         next_awready = 1'b0;
         next_wr_addr = s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
         next_wready  = 1'b0;
         next_wr_data = s_axi_wdata;
         next_wr_strb = s_axi_wstrb;
      end
      if (do_write) begin
         next_bvalid = 1'b1;
         case (wr_word)
            ADDR_W'(IDX_THR_FLAGS),
            ADDR_W'(IDX_CLAMP),
            ADDR_W'(IDX_SETUP),
            ADDR_W'(IDX_IRQ_STATUS),
            ADDR_W'(IDX_IRQ_MASK),
            ADDR_W'(IDX_DET_EN): next_bresp = RESP_OKAY;
            default:             next_bresp = RESP_SLVERR;
         endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid  = 1'b0;
         next_awready = 1'b1;
         next_wready  = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         wr_addr       <= '0;
         wr_data       <= 32'h00000000;
         wr_strb       <= 4'h0;
      end else begin
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         wr_addr       <= next_wr_addr;
         wr_data       <= next_wr_data;
         wr_strb       <= next_wr_strb;
      end
   end

   // Read path: one outstanding read, data registered one cycle after the address
   always_comb begin
      rd_take      = s_axi_arready && s_axi_arvalid;
      rd_clear     = 1'b0;
      next_arready = s_axi_arready;
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      if (rd_take) begin
         next_arready = 1'b0;
         next_rvalid  = 1'b1;
         next_rresp   = RESP_OKAY;
         case (rd_word)
            ADDR_W'(IDX_THR_FLAGS): begin
               next_rdata = {24'h000000, thr_flags};
               rd_clear   = 1'b1;
            end
            ADDR_W'(IDX_CLAMP):      next_rdata = {24'h000000, clamp_sync};
            ADDR_W'(IDX_SETUP):      next_rdata = {24'h000000, setup};
            ADDR_W'(IDX_IRQ_STATUS): next_rdata = {23'h000000, irq_status};
            ADDR_W'(IDX_IRQ_MASK):   next_rdata = {23'h000000, irq_mask};
            ADDR_W'(IDX_DET_EN):     next_rdata = {28'h0000000, det_en};
            default: begin
               next_rdata = 32'h00000000;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid  = 1'b0;
         next_arready = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
   end

   // Software registers; alert and clamp registers ignore writes
   always_comb begin
      next_setup    = setup;
      next_det_en   = det_en;
      next_irq_mask = irq_mask;
      if (do_write) begin
         case (wr_word)
            ADDR_W'(IDX_SETUP):    next_setup    = (setup & ~{8{wr_strb[0]}}) | wr_bits[7:0];
            ADDR_W'(IDX_DET_EN):   next_det_en   = (det_en & ~{4{wr_strb[0]}}) | wr_bits[3:0];
            ADDR_W'(IDX_IRQ_MASK): next_irq_mask = irq_mask ^ ((irq_mask ^ wr_data[IRQ_W-1:0])
                                                   & {wr_strb[1], {8{wr_strb[0]}}});
            default:               next_setup    = setup;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         setup    <= SETUP_RST;
         det_en   <= DET_EN_RST;
         irq_mask <= IRQ_MASK_RST;
      end else begin
         setup    <= next_setup;
         det_en   <= next_det_en;
         irq_mask <= next_irq_mask;
      end
   end

   // Alert flags: read clear, then hysteresis clear, then new alerts win
   always_comb begin
      next_thr_flags = thr_flags;
      alert_set      = 8'h00;
      if (rd_clear) begin
         next_thr_flags = 8'h00;
      end
      for (int j = 0; j < NUM_CH; j++) begin
         if (conv.valid && conv.channel == 3'(FIRST_CH + j) && det_en[j]) begin
            if (setup[ALERT_MODE_BIT] && conv.low_hyst_clear) begin
               next_thr_flags[2*j+FLAG_LOW_OFS] = 1'b0;
            end
            if (setup[ALERT_MODE_BIT] && conv.high_hyst_clear) begin
               next_thr_flags[2*j+FLAG_HIGH_OFS] = 1'b0;
            end
            if (conv.at_or_below_low) begin
               next_thr_flags[2*j+FLAG_LOW_OFS] = 1'b1;
               alert_set[2*j+FLAG_LOW_OFS]      = 1'b1;
            end
            if (conv.at_or_above_high) begin
               next_thr_flags[2*j+FLAG_HIGH_OFS] = 1'b1;
               alert_set[2*j+FLAG_HIGH_OFS]      = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         thr_flags <= THR_FLAGS_RST;
      end else begin
         thr_flags <= next_thr_flags;
      end
   end

   // Clamp inputs pass two flops; the second one is the live status
   always_ff @(posedge clock) begin
      if (rst) begin
         clamp_meta <= CLAMP_RST;
         clamp_sync <= CLAMP_RST;
         clamp_prev <= CLAMP_RST;
      end else begin
         clamp_meta <= clamp_raw;
         clamp_sync <= clamp_meta;
         clamp_prev <= clamp_sync;
      end
   end

   // Interrupt status: write one to clear, a same-cycle event wins
   always_comb begin
      next_irq_status = irq_status;
      if (do_write && wr_word == ADDR_W'(IDX_IRQ_STATUS)) begin
         next_irq_status = irq_status & ~(wr_data[IRQ_W-1:0] & {wr_strb[1], {8{wr_strb[0]}}});
      end
      next_irq_status[7:0] = next_irq_status[7:0] | alert_set;
      if (|(clamp_sync & ~clamp_prev)) begin
         next_irq_status[IRQ_CLAMP_BIT] = 1'b1;
      end
      next_irq = |(next_irq_status & next_irq_mask);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         irq_status <= IRQ_STATUS_RST;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq        <= next_irq;
      end
   end

endmodule

// ==== tb/acf_status_flags_chk.sv ====
// Checker of bus timing and read-back of the alert and clamp status flags block
`timescale 1ns/100ps
module acf_status_flags_chk
   import acf_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic               clock,
   input wire logic               rst,
   // Clamp inputs
   input wire logic [CLAMP_W-1:0] clamp_raw,
   // Write channels
   input wire logic               s_axi_awvalid,
   input wire logic               s_axi_awready,
   input wire logic               s_axi_wvalid,
   input wire logic               s_axi_wready,
   input wire logic               s_axi_bvalid,
   // Read channels
   input wire logic [ADDR_W-1:0]  s_axi_araddr,
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_arready,
   input wire logic [31:0]        s_axi_rdata,
   input wire logic [1:0]         s_axi_rresp,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_rready
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // Handshake terms
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   wire aw_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   // Read answer one edge after its request is taken, write answer one edge later still
   property p_rd_lat; ar_hs |=> s_axi_rvalid; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_wr_lat; aw_hs |-> ##2 s_axi_bvalid; endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
   // Read answer drops after its handshake, and busy channels refuse
   property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_r_drop: assert property (p_r_drop) else $error("read answer stuck");
   property p_b_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_b_busy: assert property (p_b_busy) else $error("write taken while busy");
   property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
   // Clamp read-back equals a settled input
   property p_clamp; ar_hs && s_axi_araddr == 12'h068 && $stable(clamp_raw)
      && $past(clamp_raw) == $past(clamp_raw, 2) && $past(clamp_raw, 2) == $past(clamp_raw, 3)
      |=> s_axi_rdata == {24'h000000, $past(clamp_raw)}; endproperty
   a_clamp: assert property (p_clamp) else $error("clamp read mismatch");
   // Alert register answers okay and is eight bits wide
   property p_alert_rd; ar_hs && s_axi_araddr == 12'h058
      |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h000000; endproperty
   a_alert_rd: assert property (p_alert_rd) else $error("alert read malformed");
   // Unmapped place answers an error with zero data
   property p_unmapped; ar_hs && s_axi_araddr == 12'h0FC
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
endmodule

bind acf_status_flags acf_status_flags_chk #(.ADDR_W(ADDR_W)) u_chk (
   .clock(clock), .rst(rst), .clamp_raw(clamp_raw),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ==== tb/acf_status_flags_tb.sv ====
// Self-checking bench of the alert and clamp status flags block
`timescale 1ns/100ps
module acf_status_flags_tb
   import acf_pkg::*;
;
   logic        clock = 1'b0, rst = 1'b1;
   acf_conv_t   conv = '0;
   logic [7:0]  clamp_raw = 8'h00;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata, rd_val;
   logic [3:0]  wstrb = 4'hF;
   logic [1:0]  bresp, rresp, resp;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   int          n_errors = 0, n_tests = 0, ch;

   acf_status_flags dut (.clock(clock), .rst(rst), .conv(conv), .clamp_raw(clamp_raw),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .irq(irq));

   // Clock at 20 MHz
   always #25 clock = ~clock;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Write; ready is looked at mid-cycle, so release lands right after the taking edge
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic aw_t, w_t, b_t;
      int   i;
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_t = 1'b0;
      for (i = 0; i < 50 && !b_t; i++) begin
         @(negedge clock);
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         b_t = bvalid;
         resp = bresp;
         @(posedge clock);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         if (b_t) bready <= 1'b0;
      end
      if (!b_t) begin
         n_errors++;
         conclude();
      end
   endtask

   // Read; data and response are kept in rd_val and resp
   task automatic rd(input logic [11:0] a);
      logic a_t, r_t;
      int   i;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r_t = 1'b0;
      for (i = 0; i < 50 && !r_t; i++) begin
         @(negedge clock);
         a_t = arvalid && arready;
         r_t = rvalid;
         rd_val = rdata;
         resp = rresp;
         @(posedge clock);
         if (a_t) arvalid <= 1'b0;
         if (r_t) rready <= 1'b0;
      end
      if (!r_t) begin
         n_errors++;
         conclude();
      end
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      rd(a);
      check(rd_val, e);
   endtask

   // One conversion verdict; f is low, high, low clear, high clear
   task automatic pulse(input int c, input logic [3:0] f);
      @(posedge clock);
      conv <= {1'b1, 3'(c), f};
      @(posedge clock);
      conv <= '0;
   endtask

   // Hang guard
   initial begin
      #2000000;
      n_errors++;
      conclude();
   end

   // Main sequence
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      rc(12'h058, 32'h0);
      rc(12'h068, 32'h0);
      rc(12'h080, 32'h10);
      rd(12'h0FC);
      check(32'(resp), 32'(RESP_SLVERR));
      wr(12'h0FC, 32'h0);
      check(32'(resp), 32'(RESP_SLVERR));
      // Detection off: verdicts ignored
      pulse(7, 4'hC);
      rc(12'h058, 32'h0);
      wr(12'h0C8, 32'hF);
      // Low then high flag of each channel, cleared by its read
      for (ch = 4; ch < 8; ch++) begin
         pulse(ch, 4'h8);
         rc(12'h058, 32'h1 << (2 * (ch - 4) + 1));
         pulse(ch, 4'h4);
         rc(12'h058, 32'h1 << (2 * (ch - 4)));
      end
      rc(12'h058, 32'h0);
      pulse(5, 4'h4);
      wr(12'h058, 32'hFF);
      check(32'(resp), 32'(RESP_OKAY));
      rc(12'h058, 32'h04);
      // Hysteresis clear ignored in mode 0, honoured in mode 1
      pulse(6, 4'h4);
      pulse(6, 4'h1);
      rc(12'h058, 32'h10);
      wr(12'h080, 32'h90);
      rc(12'h080, 32'h90);
      pulse(6, 4'h8);
      pulse(6, 4'h2);
      rc(12'h058, 32'h0);
      wr(12'h080, 32'h10);
      rc(12'h080, 32'h10);
      // Detection is enabled per channel
      wr(12'h0C8, 32'hE);
      pulse(4, 4'h8);
      rc(12'h058, 32'h0);
      wr(12'h0C8, 32'hF);
      // New alert in the clearing read's cycle survives
      pulse(4, 4'h4);
      fork
         rd(12'h058);
         pulse(7, 4'h8);
      join
      check(rd_val, 32'h01);
      rc(12'h058, 32'h80);
      // Clamp flags follow the inputs without latching
      clamp_raw <= 8'hA5;
      repeat (4) @(posedge clock);
      wr(12'h068, 32'h0);
      rc(12'h068, 32'hA5);
      clamp_raw <= 8'h00;
      repeat (4) @(posedge clock);
      rc(12'h068, 32'h0);
      // Interrupt held back by mask, raised, then cleared
      wr(12'h0C0, 32'h1FF);
      pulse(4, 4'h8);
      repeat (2) @(negedge clock);
      check(32'(irq), 32'h0);
      rc(12'h0C0, 32'h002);
      wr(12'h0C4, 32'h002);
      @(negedge clock);
      check(32'(irq), 32'h1);
      wr(12'h0C0, 32'h002);
      @(negedge clock);
      check(32'(irq), 32'h0);
      conclude();
   end
endmodule
